// ### rtl/cbap_regs.svh
// Register offsets, field positions, reset values and timing counts of the arbitration point.
// Assumes a 100 MHz clock; included by bare name.
`ifndef CBAP_REGS_SVH
`define CBAP_REGS_SVH
`define CBAP_CSR_ADDR       16'h0090
`define CBAP_BIT_CPU_EN     7
`define CBAP_BIT_FORCE      6
`define CBAP_BIT_EXT        5
`define CBAP_CSR_RESET      8'h00
`define CBAP_CLK_NS         10
`define CBAP_ARB_MIN_NS     300
`define CBAP_ARB_EXT_NS     600
`define CBAP_ARB_MIN_CYC    ((`CBAP_ARB_MIN_NS + `CBAP_CLK_NS - 1) / `CBAP_CLK_NS)
`define CBAP_ARB_EXT_CYC    ((`CBAP_ARB_EXT_NS + `CBAP_CLK_NS - 1) / `CBAP_CLK_NS)
`define CBAP_LEVEL_CPU      4'hf
`endif

// ### rtl/cbap_pkg.sv
// Types shared by the arbitration point modules.
// Assumes nothing of its surroundings.
package cbap_pkg;
  typedef enum logic [2:0]
  {
    ST_GRANT = 3'b000,
    ST_ARB   = 3'b001,
    ST_WAIT  = 3'b011,
    ST_SYS   = 3'b010
  } cbap_state_e;
  typedef logic [3:0] cbap_level_t;
endpackage : cbap_pkg

// ### rtl/cbap_timer_if.sv
// Interface joining the arbitration controller and its cycle timer.
// Assumes one clock shared by both sides.
`timescale 1ns/100ps
interface cbap_timer_if;
  logic start;
  logic extended;
  logic done;
  modport ctrl (output start, output extended, input done);
  modport tmr  (input start, input extended, output done);
endinterface : cbap_timer_if

// ### rtl/cbap_timer.sv
// Minimum arbitration cycle timer: 300 ns normally, 600 ns when extended.
// Assumes a start pulse from the controller on the same clock.
`timescale 1ns/100ps
`include "cbap_regs.svh"
module cbap_timer
(
  // Clock and reset.
  input wire logic   clock,
  input wire logic   resetn,
  // Controller side.
  cbap_timer_if.tmr  tif
);
  logic [7:0] count;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      count <= 8'h00;
    else if (tif.start)
      count <= tif.extended ? 8'(`CBAP_ARB_EXT_CYC - 1) : 8'(`CBAP_ARB_MIN_CYC - 1);
    else if (count != 8'h00)
      count <= count - 8'h01;
  end

  assign tif.done = (count == 8'h00) && !tif.start;
endmodule : cbap_timer

// ### rtl/cbap_arbiter.sv
// Central arbitration control point with its control/status register at I/O 0090.
// Assumes a synchronous host I/O strobe and channel signals arriving asynchronously.
`timescale 1ns/100ps
`include "cbap_regs.svh"
//Function
// - The arbiter resolves ownership among up to sixteen levels on the four arbitration lines.
// - The lowest level number presented wins.
// - DMA channels default to levels 0 to 7, and channels 0 and 4 may be moved to any level.
// - Refresh is served at level -2, above every channel level.
// - Levels -1 and -2 are used only by system-board logic during the arbitrate phase.
// - An NMI asserts takeover, waits for the transfer end, holds arbitrate and grants -1 until cleared.
// - The register sits at I/O 0090 and its bits mean different things for reads and writes.
// - Bit 7 enables processor cycles during arbitration, resets to 0 and reads back.
// - Writing bit 6 forces the arbitration state until written back to 0, and resets to 0.
// - Reading bit 6 shows that an NMI has masked arbitration.
// - Bit 5 stretches the minimum arbitration cycle from 300 ns to 600 ns and resets to 0.
// - Reading bit 5 shows a bus time-out, and that read clears the masked bit 6.
// - Bits 3 to 0 read the level latched in the last grant state.
module cbap_arbiter
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        resetn,
  // Host I/O register port.
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // Channel arbitration lines.
  input  wire logic [3:0]  arb_in,
  input  wire logic        arb_req_n,
  input  wire logic        xfer_end,
  output logic             bus_takeover_request_n,
  output logic             arbitrate_grant_phase,
  output logic      [3:0]  granted_level,
  // System-board requests.
  input  wire logic        refresh_req,
  input  wire logic        nmi_req,
  input  wire logic        bus_timeout,
  output logic             refresh_grant,
  output logic             nmi_grant,
  output logic             cpu_cycles_enabled
);
  cbap_pkg::cbap_state_e state;
  cbap_timer_if          tif ();
  logic [3:0]            arb_s1;
  logic [3:0]            arb_s2;
  logic [4:0]            req_s1;
  logic [4:0]            req_s2;
  logic                  cpu_en;
  logic                  force_arb;
  logic                  ext_arb;
  logic                  nmi_mask;
  logic                  timeout_flag;
  logic [3:0]            last_level;
  logic                  csr_hit;
  logic                  req_n_s;
  logic                  end_s;
  logic                  nmi_s;
  logic                  to_s;
  logic                  sys_pending;

  cbap_timer u_timer
  (
    .clock  (clock),
    .resetn (resetn),
    .tif    (tif)
  );

  // Channel pins are brought into the clock domain before use.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      arb_s1 <= 4'hf;
      arb_s2 <= 4'hf;
      req_s1 <= 5'h01;
      req_s2 <= 5'h01;
    end
    else
    begin
      arb_s1 <= arb_in;
      arb_s2 <= arb_s1;
      req_s1 <= {bus_timeout, nmi_req, xfer_end, 1'b0, arb_req_n} | 5'h00;
      req_s2 <= req_s1;
    end
  end

  assign req_n_s     = req_s2[0];
  assign end_s       = req_s2[2];
  assign nmi_s       = req_s2[3];
  assign to_s        = req_s2[4];
  assign sys_pending = nmi_s || refresh_req || force_arb;
  assign csr_hit     = (io_addr == `CBAP_CSR_ADDR);

  // Write side of the register.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cpu_en    <= 1'b0;
      force_arb <= 1'b0;
      ext_arb   <= 1'b0;
    end
    else if (io_wr && csr_hit)
    begin
      cpu_en    <= io_wdata[`CBAP_BIT_CPU_EN];
      force_arb <= io_wdata[`CBAP_BIT_FORCE];
      ext_arb   <= io_wdata[`CBAP_BIT_EXT];
    end
  end

  // NMI mask flag: a new NMI wins over the clearing read.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      nmi_mask <= 1'b0;
    else if (nmi_s)
      nmi_mask <= 1'b1;
    else if (io_rd && csr_hit && timeout_flag)
      nmi_mask <= 1'b0;
  end

  // Time-out flag stays until reset.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      timeout_flag <= 1'b0;
    else if (to_s)
      timeout_flag <= 1'b1;
  end

  always_comb
  begin
    io_rdata = 8'h00;
    if (csr_hit)
      io_rdata = {cpu_en, nmi_mask, timeout_flag, 1'b0, last_level};
  end

  // Arbitration sequence.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      state <= cbap_pkg::ST_GRANT;
    else
      case (state)
        cbap_pkg::ST_GRANT:
          if (nmi_s || refresh_req)
            state <= cbap_pkg::ST_WAIT;
          else if (force_arb || !req_n_s)
            state <= cbap_pkg::ST_ARB;
        cbap_pkg::ST_WAIT:
          if (end_s || force_arb)
            state <= cbap_pkg::ST_SYS;
        cbap_pkg::ST_SYS:
          if (!nmi_s && !refresh_req && !force_arb)
            state <= cbap_pkg::ST_ARB;
        cbap_pkg::ST_ARB:
          if (nmi_s || refresh_req)
            state <= cbap_pkg::ST_SYS;
          else if (tif.done && !force_arb)
            state <= cbap_pkg::ST_GRANT;
        default:
          state <= cbap_pkg::ST_GRANT;
      endcase
  end

  assign tif.start    = (state == cbap_pkg::ST_GRANT) && !(nmi_s || refresh_req) && (force_arb || !req_n_s);
  assign tif.extended = ext_arb;

  // Winning level is taken when the grant phase begins; wired-AND lines give the lowest level.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      granted_level <= `CBAP_LEVEL_CPU;
      last_level    <= 4'h0;
    end
    else if (state == cbap_pkg::ST_ARB && tif.done && !sys_pending)
    begin
      granted_level <= req_n_s ? `CBAP_LEVEL_CPU : arb_s2;
      last_level    <= req_n_s ? `CBAP_LEVEL_CPU : arb_s2;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      refresh_grant <= 1'b0;
      nmi_grant     <= 1'b0;
    end
    else
    begin
      refresh_grant <= (state == cbap_pkg::ST_SYS) && refresh_req;
      nmi_grant     <= (state == cbap_pkg::ST_SYS) && nmi_s && !refresh_req;
    end
  end

  assign bus_takeover_request_n = !(state == cbap_pkg::ST_WAIT);
  // The phase stays in grant while the takeover waits for the running transfer to end.
  assign arbitrate_grant_phase  = (state != cbap_pkg::ST_GRANT) && (state != cbap_pkg::ST_WAIT);
  assign cpu_cycles_enabled     = cpu_en || force_arb || (state == cbap_pkg::ST_GRANT);

  AST_NMI_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    nmi_grant |-> arbitrate_grant_phase) else $error("nmi grant outside arbitrate");
  AST_REFRESH_ARB: assert property (@(posedge clock) disable iff (!resetn)
    refresh_grant |-> arbitrate_grant_phase) else $error("refresh grant outside arbitrate");
  AST_FORCE: assert property (@(posedge clock) disable iff (!resetn)
    force_arb && state == cbap_pkg::ST_ARB |=> arbitrate_grant_phase) else $error("force ignored");
  AST_WR_CPU: assert property (@(posedge clock) disable iff (!resetn)
    io_wr && csr_hit |=> cpu_en == $past(io_wdata[7])) else $error("bit 7 write lost");
  AST_WR_EXT: assert property (@(posedge clock) disable iff (!resetn)
    io_wr && csr_hit |=> ext_arb == $past(io_wdata[5])) else $error("bit 5 write lost");
  AST_MASK_CLR: assert property (@(posedge clock) disable iff (!resetn)
    io_rd && csr_hit && timeout_flag && !nmi_s |=> !nmi_mask) else $error("mask not cleared");
  AST_READ: assert property (@(posedge clock) disable iff (!resetn)
    csr_hit |-> io_rdata[3:0] == last_level && io_rdata[4] == 1'b0) else $error("read level wrong");
  AST_IDLE_CPU: assert property (@(posedge clock) disable iff (!resetn)
    state == cbap_pkg::ST_ARB && tif.done && !sys_pending && req_n_s |=> granted_level == 4'hf)
    else $error("idle not cpu");
  AST_MIN_ARB: assert property (@(posedge clock) disable iff (!resetn)
    $rose(arbitrate_grant_phase) && !ext_arb && !sys_pending |-> arbitrate_grant_phase [*8])
    else $error("arbitration too short");

  COV_GRANT: cover property (@(posedge clock) disable iff (!resetn) !req_n_s ##[1:60] !arbitrate_grant_phase);
  COV_NMI: cover property (@(posedge clock) disable iff (!resetn) nmi_grant);
  COV_REFRESH: cover property (@(posedge clock) disable iff (!resetn) refresh_grant);
endmodule : cbap_arbiter

// ### sim/cbap_channel_model.sv
// Behavioural channel masters driving the wired arbitration lines.
// Assumes the bench commands requests on the shared clock; idle lines pull up to F.
`timescale 1ns/100ps
module cbap_channel_model
(
  // Clock.
  input  wire logic       clock,
  // Bench commands.
  input  wire logic       want_a,
  input  wire logic       want_b,
  input  wire logic [3:0] level_a,
  input  wire logic [3:0] level_b,
  input  wire logic       end_xfer,
  // Channel lines.
  output logic      [3:0] arb_in,
  output logic            arb_req_n,
  output logic            xfer_end
);
  initial
  begin
    arb_in = 4'hf;
    arb_req_n = 1'b1;
    xfer_end = 1'b0;
  end
  // The wired lines leave the lowest competing level; released lines float high.
  always @(posedge clock)
  begin
    arb_in <= (want_a && (!want_b || level_a < level_b)) ? level_a : (want_b ? level_b : 4'hf);
    arb_req_n <= !(want_a || want_b);
    xfer_end <= end_xfer;
  end
endmodule : cbap_channel_model

// ### sim/tb_central_bus_arbitration_point.sv
// Self-checking bench for the arbitration point: register, arbitration, NMI and refresh.
// Assumes the channel model file is compiled first.
`timescale 1ns/100ps
module tb_central_bus_arbitration_point;
  logic clock, resetn, io_wr, io_rd, refresh_req, nmi_req, bus_timeout, arb_req_n, xfer_end;
  logic want_a, want_b, end_xfer, takeover_n, phase, refresh_grant, nmi_grant, cpu_en;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, v;
  logic [3:0]  arb_in, level_a, level_b, granted_level;
  int          mismatches, samples_checked, cyc, n;
  cbap_arbiter dut (.clock(clock), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .arb_in(arb_in), .arb_req_n(arb_req_n), .xfer_end(xfer_end),
    .bus_takeover_request_n(takeover_n), .arbitrate_grant_phase(phase), .granted_level(granted_level),
    .refresh_req(refresh_req), .nmi_req(nmi_req), .bus_timeout(bus_timeout), .refresh_grant(refresh_grant),
    .nmi_grant(nmi_grant), .cpu_cycles_enabled(cpu_en));
  cbap_channel_model chan (.clock(clock), .want_a(want_a), .want_b(want_b), .level_a(level_a),
    .level_b(level_b), .end_xfer(end_xfer), .arb_in(arb_in), .arb_req_n(arb_req_n), .xfer_end(xfer_end));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task conclude;
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task wr(input logic [7:0] d);
    @(posedge clock);
    io_addr <= 16'h0090;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clock);
    io_wr <= 1'b0;
  endtask : wr
  task rd(input logic [15:0] a);
    @(posedge clock);
    io_addr <= a;
    io_rd <= 1'b1;
    @(negedge clock);
    v = io_rdata;
    @(posedge clock);
    io_rd <= 1'b0;
  endtask : rd
  task wait_for(input logic want, input logic sig_sel);
    n = 0;
    do @(negedge clock); while (((sig_sel ? nmi_grant : phase) !== want) && ++n < 200);
  endtask : wait_for
  // One arbitration cycle: time the arbitrate phase and check the winner.
  // The masters hold their levels until the release reaches the synchronised lines just after the grant edge.
  task arb_run(input logic [3:0] a, input logic [3:0] b, input logic [3:0] win, input logic cpu, input int len);
    level_a <= a;
    level_b <= b;
    want_a <= 1'b1;
    want_b <= (b != 4'hf);
    wait_for(1'b1, 1'b0);
    chk(cpu_en, cpu);
    n = 0;
    while (phase === 1'b1 && n < 250)
    begin
      n++;
      if (n == len - 2)
      begin
        want_a <= 1'b0;
        want_b <= 1'b0;
      end
      @(negedge clock);
    end
    chk(n, len);
    chk(granted_level, win);
    rd(16'h0090);
    chk(v[3:0], win);
  endtask : arb_run
  always @(posedge clock) if (++cyc == 20000) begin mismatches++; conclude; end
  initial
  begin
    {resetn, io_wr, io_rd, refresh_req, nmi_req, bus_timeout, want_a, want_b, end_xfer} = '0;
    {io_addr, io_wdata, level_a, level_b} = '0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    chk({phase, takeover_n, granted_level}, 6'h1f);
    rd(16'h0090);
    chk(v & 8'he0, 8'h00);
    wr(8'h80);
    rd(16'h0090);
    chk(v & 8'he0, 8'h80);
    chk(cpu_en, 1'b1);
    rd(16'h0091);
    chk(v, 8'h00);
    arb_run(4'h5, 4'h3, 4'h3, 1'b1, 30);
    wr(8'h00);
    chk(cpu_en, 1'b1);
    arb_run(4'h0, 4'he, 4'h0, 1'b0, 30);
    wr(8'h20);
    arb_run(4'he, 4'hf, 4'he, 1'b0, 60);
    wr(8'h40);
    repeat (100) @(negedge clock);
    chk(phase, 1'b1);
    chk(cpu_en, 1'b1);
    chk(granted_level, 4'he);
    rd(16'h0090);
    chk(v & 8'h4f, 8'h0e);
    wr(8'h00);
    wait_for(1'b0, 1'b0);
    chk(phase, 1'b0);
    chk(granted_level, 4'hf);
    @(posedge clock);
    nmi_req <= 1'b1;
    repeat (8) @(negedge clock);
    chk({takeover_n, phase, nmi_grant}, 3'b000);
    end_xfer <= 1'b1;
    wait_for(1'b1, 1'b1);
    chk({phase, nmi_grant}, 2'b11);
    @(posedge clock);
    end_xfer <= 1'b0;
    nmi_req <= 1'b0;
    bus_timeout <= 1'b1;
    wait_for(1'b0, 1'b1);
    wait_for(1'b0, 1'b0);
    chk(phase, 1'b0);
    rd(16'h0090);
    chk(v & 8'h60, 8'h60);
    rd(16'h0090);
    chk(v & 8'h60, 8'h20);
    bus_timeout <= 1'b0;
    refresh_req <= 1'b1;
    end_xfer <= 1'b1;
    repeat (10) @(negedge clock);
    chk({phase, refresh_grant}, 2'b11);
    refresh_req <= 1'b0;
    conclude;
  end
endmodule : tb_central_bus_arbitration_point
